// *** core/efs_defines.svh ***
`ifndef EFS_DEFINES_SVH
`define EFS_DEFINES_SVH

// timeslot 0 words
`define EFS_FAS_PAT 7'h1B
`define EFS_NFAS_BIT 6
`define EFS_CRC_BIT 7
`define EFS_CRC_MFAS 6'h0B
// channel numbers
`define EFS_TS0 5'h00
`define EFS_TS16 5'h10
`define EFS_MASTER_CONTROL_WORD_ONE_CH 5'h0F
`define EFS_MCW2_CH 5'h1F
// per-channel and master word fields
`define EFS_DATA_BIT 7
`define EFS_LOOP_BIT 6
`define EFS_RXG_HI 5
`define EFS_RXG_LO 3
`define EFS_TXG_HI 2
`define EFS_TXG_LO 0
`define EFS_MASTER_CONTROL_WORD_ONE_RST 8'hB0
`define EFS_ADI_MASK 8'h55
// framing counts
`define EFS_FAS_LOSS 2'h3
`define EFS_MF_LOSS 2'h2
`define EFS_DB_AGE 2'h3
`define EFS_CRC_ERR_MAX 914
// times
`define EFS_CLK_NS 25
`define EFS_CRC_TO_NS 8000000
`define EFS_ONE_SEC_NS 1000000000

`endif

// *** core/efs_pkg.sv ***
package efs_pkg;

	// frame-alignment framer, gray along search path
	typedef enum logic [1:0] {
		FA_SEARCH = 2'h0,
		FA_NFAS = 2'h1,
		FA_FAS = 2'h3,
		FA_SYNC = 2'h2
	} efs_fa_t;

	// one received timeslot leaving the block
	typedef struct packed {
		logic [7:0] data;
		logic [4:0] ts;
		logic [2:0] gain_code;
		logic signed [3:0] gain_db;
		logic bypass;
	} efs_rx_word_t;

	// 000..110 give 0..-6 dB, 111 gives +1 dB
	function automatic logic signed [3:0] efs_gain_db(input logic [2:0] code);
		efs_gain_db = (code == 3'h7) ? 4'sh1 : -$signed({1'b0, code});
	endfunction

endpackage

// *** core/efs_fifo.sv ***
module efs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	// full and empty come straight from the fill count
	assign in_ready_out = (cnt_r != DEPTH[AW:0]);
	assign out_valid_out = (cnt_r != '0);
	assign push = ce_in && in_valid_in && in_ready_out;
	assign pop = ce_in && out_valid_out && out_ready_in;
	assign out_data_out = mem_r[rp_r];

	// storage, no reset needed for data
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem_r[wp_r] <= in_data_in;
		end
	end

	// pointers and count
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule

// *** core/efs_core.sv ***
`include "efs_defines.svh"

module efs_core #(
	parameter int FIFO_DEPTH = 8,
	parameter int CRC_TO_CYC = `EFS_CRC_TO_NS / `EFS_CLK_NS,
	parameter int SEC_CYC = `EFS_ONE_SEC_NS / `EFS_CLK_NS
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// received line, one byte per timeslot
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_byte_in,
	output logic rx_ready_out,
	// transmitted timeslots
	input wire logic tx_valid_in,
	input wire logic [4:0] tx_ts_in,
	input wire logic [7:0] tx_byte_in,
	// control_input_stream_0
	input wire logic ctl_valid_in,
	input wire logic [4:0] ctl_ch_in,
	input wire logic [7:0] ctl_byte_in,
	// pins
	input wire logic alt_digit_inversion_select_in,
	input wire logic maint_in,
	input wire logic crc_err_in,
	// data_output_stream words
	output logic out_valid_out,
	input wire logic out_ready_in,
	output efs_pkg::efs_rx_word_t out_word_out,
	// transmit gain for the last transmitted timeslot
	output logic [2:0] tx_gain_code_out,
	output logic signed [3:0] tx_gain_db_out,
	output logic tx_bypass_out,
	// debounced signalling, high nibble channel f, low nibble f+16
	output logic sig_valid_out,
	output logic [3:0] sig_frame_out,
	output logic [7:0] sig_abcd_out,
	// framer state
	output logic fa_sync_out,
	output logic mf_sync_out,
	output logic crc_sync_out
);
	localparam int TOW = $clog2(CRC_TO_CYC + 1);
	localparam int SCW = $clog2(SEC_CYC + 1);

	efs_pkg::efs_fa_t fa_r;
	logic [4:0] ts_r;
	logic nfas_next_r;
	logic [1:0] fas_err_r;
	logic mf_sync_r;
	logic [3:0] frm_r;
	logic [1:0] mf_err_r;
	logic crc_sync_r;
	logic crc_once_r;
	logic [4:0] crc_sh_r;
	logic [TOW-1:0] crc_to_r;
	logic [SCW-1:0] sec_r;
	logic [9:0] crc_cnt_r;
	logic reframe_r;
	logic [7:0] master_control_word_one_r;
	logic [7:0] pcw_r [32];
	logic [7:0] txm_r [32];
	logic [7:0] stab_r [16];
	logic [7:0] cand_r [16];
	logic [3:0] age_r [16];
	logic ev;
	logic fas_hit;
	logic fa_sync;
	logic at_ts0;
	logic at_ts16;
	logic [7:0] rx_ctl;
	logic [7:0] tx_ctl;
	logic loop_sel;
	logic [7:0] sel_byte;
	logic rx_bypass;
	logic crc_hit;
	logic mf_err_ev;
	logic to_ev;
	logic cnt_ev;
	logic [3:0] nd_mask;
	logic [7:0] st_nxt;
	logic [7:0] cd_nxt;
	logic [3:0] ag_nxt;
	efs_pkg::efs_rx_word_t wr_word;

	assign ev = ce_in && rx_valid_in && rx_ready_out;
	assign fa_sync = (fa_r == efs_pkg::FA_SYNC);
	assign fas_hit = (rx_byte_in[6:0] == `EFS_FAS_PAT);
	assign at_ts0 = (ts_r == `EFS_TS0);
	assign at_ts16 = (ts_r == `EFS_TS16);
	assign fa_sync_out = fa_sync;
	assign mf_sync_out = mf_sync_r;
	assign crc_sync_out = crc_sync_r;

	// timeslot counter; realigned when the search finds a FAS
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ts_r <= '0;
		end else if (ev) begin
			if (fa_r == efs_pkg::FA_SEARCH && fas_hit) begin
				ts_r <= 5'h01;
			end else begin
				ts_r <= ts_r + 5'h01;
			end
		end
	end

	// frame-alignment framer
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			fa_r <= efs_pkg::FA_SEARCH;
			nfas_next_r <= 1'b0;
			fas_err_r <= '0;
		end else if (ce_in && reframe_r) begin
			fa_r <= efs_pkg::FA_SEARCH;
		end else if (ev) begin
			case (fa_r)
				efs_pkg::FA_SEARCH: begin
					if (fas_hit) begin
						fa_r <= efs_pkg::FA_NFAS;
					end
				end
				efs_pkg::FA_NFAS: begin
					if (at_ts0) begin
						fa_r <= rx_byte_in[`EFS_NFAS_BIT] ? efs_pkg::FA_FAS : efs_pkg::FA_SEARCH;
					end
				end
				efs_pkg::FA_FAS: begin
					if (at_ts0) begin
						fa_r <= fas_hit ? efs_pkg::FA_SYNC : efs_pkg::FA_SEARCH;
						nfas_next_r <= 1'b1;
						fas_err_r <= '0;
					end
				end
				efs_pkg::FA_SYNC: begin
					if (at_ts0) begin
						nfas_next_r <= !nfas_next_r;
						if (!nfas_next_r) begin
							// a few corrupted words must not drop a good link
							fas_err_r <= fas_hit ? 2'h0 : fas_err_r + 2'h1;
							if (!fas_hit && fas_err_r == `EFS_FAS_LOSS - 2'h1) begin
								fa_r <= efs_pkg::FA_SEARCH;
							end
						end
					end
				end
				default: begin
					fa_r <= efs_pkg::FA_SEARCH;
				end
			endcase
		end
	end

	// multiframe framer
	assign mf_err_ev = mf_sync_r && frm_r == 4'h0 && rx_byte_in[7:4] != 4'h0;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			mf_sync_r <= 1'b0;
			frm_r <= '0;
			mf_err_r <= '0;
		end else if (ce_in && !fa_sync) begin
			mf_sync_r <= 1'b0;
			mf_err_r <= '0;
		end else if (ev && at_ts16) begin
			if (!mf_sync_r) begin
				if (rx_byte_in[7:4] == 4'h0) begin
					mf_sync_r <= 1'b1;
					frm_r <= 4'h1;
				end
			end else begin
				frm_r <= frm_r + 4'h1;
				if (mf_err_ev) begin
					mf_err_r <= mf_err_r + 2'h1;
					if (mf_err_r == `EFS_MF_LOSS - 2'h1) begin
						mf_sync_r <= 1'b0;
						mf_err_r <= '0;
					end
				end else if (frm_r == 4'h0) begin
					// a clean alignment word breaks the run of errors
					mf_err_r <= '0;
				end
			end
		end
	end

	// CRC framer, looks only at NFAS bit 1
	assign crc_hit = ({crc_sh_r, rx_byte_in[`EFS_CRC_BIT]} == `EFS_CRC_MFAS);
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			crc_sync_r <= 1'b0;
			crc_once_r <= 1'b0;
			crc_sh_r <= '0;
		end else if (ce_in && !fa_sync) begin
			crc_sync_r <= 1'b0;
			crc_once_r <= 1'b0;
			crc_sh_r <= '0;
		end else if (ev && at_ts0 && nfas_next_r) begin
			crc_sh_r <= {crc_sh_r[3:0], rx_byte_in[`EFS_CRC_BIT]};
			if (crc_hit) begin
				crc_once_r <= 1'b1;
				if (crc_once_r) begin
					crc_sync_r <= 1'b1;
				end
			end
		end
	end

	// maintenance supervision: search timeout and error rate
	assign to_ev = (crc_to_r == TOW'(CRC_TO_CYC - 1));
	assign cnt_ev = crc_err_in && crc_sync_r;
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			crc_to_r <= '0;
			sec_r <= '0;
			crc_cnt_r <= '0;
			reframe_r <= 1'b0;
		end else if (ce_in) begin
			reframe_r <= 1'b0;
			crc_to_r <= (fa_sync && !crc_sync_r && !to_ev) ? crc_to_r + 1'b1 : '0;
			if (maint_in && fa_sync && !crc_sync_r && to_ev) begin
				reframe_r <= 1'b1;
			end
			if (sec_r == SCW'(SEC_CYC - 1)) begin
				sec_r <= '0;
				crc_cnt_r <= '0;
			end else begin
				sec_r <= sec_r + 1'b1;
				if (cnt_ev && crc_cnt_r != 10'h3FF) begin
					crc_cnt_r <= crc_cnt_r + 10'h001;
				end
			end
			if (maint_in && crc_cnt_r > 10'(`EFS_CRC_ERR_MAX)) begin
				reframe_r <= 1'b1;
				crc_cnt_r <= '0;
			end
		end
	end

	// control stream capture; channel 31 belongs to another word
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			master_control_word_one_r <= `EFS_MASTER_CONTROL_WORD_ONE_RST;
			for (int i = 0; i < 32; i++) begin
				pcw_r[i] <= 8'h00;
			end
		end else if (ce_in && ctl_valid_in) begin
			if (ctl_ch_in == `EFS_MASTER_CONTROL_WORD_ONE_CH) begin
				master_control_word_one_r <= ctl_byte_in;
			end else if (ctl_ch_in != `EFS_MCW2_CH) begin
				pcw_r[ctl_ch_in] <= ctl_byte_in;
			end
		end
	end

	// receive data path: control of channel N steers timeslot N+1
	assign rx_ctl = (ts_r == 5'h10) ? master_control_word_one_r : pcw_r[ts_r - 5'h01];
	assign tx_ctl = pcw_r[tx_ts_in - 5'h01];
	always_comb begin
		if (at_ts16) begin
			loop_sel = fa_sync && master_control_word_one_r[`EFS_LOOP_BIT];
		end else begin
			loop_sel = fa_sync && !at_ts0 && rx_ctl[`EFS_LOOP_BIT];
		end
	end
	assign sel_byte = loop_sel ? txm_r[ts_r] : rx_byte_in;
	assign rx_bypass = rx_ctl[`EFS_DATA_BIT] || at_ts0 || at_ts16;
	always_comb begin
		wr_word.ts = ts_r;
		wr_word.bypass = rx_bypass;
		wr_word.gain_code = rx_bypass ? 3'h0 : rx_ctl[`EFS_RXG_HI:`EFS_RXG_LO];
		wr_word.gain_db = efs_pkg::efs_gain_db(wr_word.gain_code);
		if (!rx_bypass && alt_digit_inversion_select_in) begin
			wr_word.data = sel_byte ^ `EFS_ADI_MASK;
		end else begin
			wr_word.data = sel_byte;
		end
	end

	// transmitted bytes kept for loopback, gain for the transmitter
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			tx_gain_code_out <= '0;
			tx_gain_db_out <= '0;
			tx_bypass_out <= 1'b0;
		end else if (ce_in && tx_valid_in) begin
			txm_r[tx_ts_in] <= tx_byte_in;
			tx_bypass_out <= tx_ctl[`EFS_DATA_BIT];
			if (tx_ctl[`EFS_DATA_BIT]) begin
				tx_gain_code_out <= 3'h0;
				tx_gain_db_out <= 4'sh0;
			end else begin
				tx_gain_code_out <= tx_ctl[`EFS_TXG_HI:`EFS_TXG_LO];
				tx_gain_db_out <= efs_pkg::efs_gain_db(tx_ctl[`EFS_TXG_HI:`EFS_TXG_LO]);
			end
		end
	end

	// per-half debounce of the timeslot 16 nibbles
	assign nd_mask = {master_control_word_one_r[0], master_control_word_one_r[1], master_control_word_one_r[2], master_control_word_one_r[3]};
	for (genvar h = 0; h < 2; h++) begin : g_db
		logic [3:0] smp;
		logic [3:0] st;
		logic [3:0] cd;
		logic [1:0] ag;
		assign smp = rx_byte_in[h*4 +: 4];
		assign st = stab_r[frm_r][h*4 +: 4];
		assign cd = cand_r[frm_r][h*4 +: 4];
		assign ag = age_r[frm_r][h*2 +: 2];
		// an isolated bit error must persist 6-8 ms before it reaches the output
		always_comb begin
			cd_nxt[h*4 +: 4] = smp;
			if (((smp ^ st) & ~nd_mask) == 4'h0) begin
				st_nxt[h*4 +: 4] = (st & ~nd_mask) | (smp & nd_mask);
				ag_nxt[h*2 +: 2] = 2'h0;
			end else if (smp != cd) begin
				st_nxt[h*4 +: 4] = (st & ~nd_mask) | (smp & nd_mask);
				ag_nxt[h*2 +: 2] = 2'h1;
			end else if (ag == `EFS_DB_AGE) begin
				st_nxt[h*4 +: 4] = smp;
				ag_nxt[h*2 +: 2] = 2'h0;
			end else begin
				st_nxt[h*4 +: 4] = (st & ~nd_mask) | (smp & nd_mask);
				ag_nxt[h*2 +: 2] = ag + 2'h1;
			end
		end
	end

	// signalling store and report
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			sig_valid_out <= 1'b0;
			sig_frame_out <= '0;
			sig_abcd_out <= '0;
			for (int i = 0; i < 16; i++) begin
				stab_r[i] <= 8'h00;
				cand_r[i] <= 8'h00;
				age_r[i] <= 4'h0;
			end
		end else if (ce_in) begin
			sig_valid_out <= 1'b0;
			if (ev && at_ts16 && mf_sync_r && frm_r != 4'h0) begin
				stab_r[frm_r] <= st_nxt;
				cand_r[frm_r] <= cd_nxt;
				age_r[frm_r] <= ag_nxt;
				sig_valid_out <= 1'b1;
				sig_frame_out <= frm_r;
				sig_abcd_out <= st_nxt;
			end
		end
	end

	// output buffer; a stalled reader holds off the line source
	efs_fifo #(
		.WIDTH($bits(efs_pkg::efs_rx_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.in_valid_in(rx_valid_in),
		.in_ready_out(rx_ready_out),
		.in_data_in(wr_word),
		.out_valid_out(out_valid_out),
		.out_ready_in(out_ready_in),
		.out_data_out(out_word_out)
	);

	// checks
	sequence s_fas;
		ev && at_ts0 && fas_hit;
	endsequence
	sequence s_start;
		ev && fa_r == efs_pkg::FA_SEARCH && fas_hit && !reframe_r;
	endsequence

	a_mf_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ce_in && !fa_sync |=> !mf_sync_r) else $error("multiframe sync without frame sync");
	a_mf_declare: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ev && fa_sync && at_ts16 && !mf_sync_r && rx_byte_in[7:4] == 4'h0 |=> mf_sync_r)
		else $error("multiframe sync not declared");
	a_mf_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		mf_sync_r && ce_in && fa_sync && !(ev && at_ts16 && mf_err_ev) |=> mf_sync_r)
		else $error("multiframe sync dropped without cause");
	a_crc_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ce_in && !fa_sync |=> !crc_sync_r && !crc_once_r) else $error("CRC framer ran early");
	a_crc_declare: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ev && fa_sync && at_ts0 && nfas_next_r && crc_hit && crc_once_r |=> crc_sync_r)
		else $error("CRC sync not declared");
	a_crc_reframe: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ce_in && maint_in && fa_sync && !crc_sync_r && to_ev ##1 ce_in
		|=> fa_r == efs_pkg::FA_SEARCH) else $error("no reframe on CRC timeout");
	a_loop_data: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ev && loop_sel && (rx_bypass || !alt_digit_inversion_select_in)
		|-> wr_word.data == txm_r[ts_r] && fa_sync) else $error("loop data wrong");
	a_gain_map: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		ev && !rx_bypass && rx_ctl[5:3] == 3'h7 |-> wr_word.gain_db == 4'sh1)
		else $error("all-ones gain not +1 dB");
	a_fa_declare: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(fa_sync) |-> $past(fa_r) == efs_pkg::FA_FAS) else $error("sync skipped steps");
endmodule

// *** bench/efs_ctl_model.sv ***
module efs_ctl_model (
	// clock
	input wire logic clock_in,
	// requests from the bench
	input wire logic req_in,
	input wire logic [4:0] ch_in,
	input wire logic [7:0] byte_in,
	// control_input_stream_0 towards the device
	output logic ctl_valid_out,
	output logic [4:0] ctl_ch_out,
	output logic [7:0] ctl_byte_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] loop_own_r;
	logic [7:0] w;

	// quiet stream before the first word
	initial begin
		ctl_valid_out = 1'b0;
		ctl_ch_out = 5'h00;
		ctl_byte_out = 8'h00;
		loop_own_r = 6'h00;
	end

	// one word per request; idle lines toggle so stale data is never mistaken for a word
	always @(posedge clock_in) begin
		w = byte_in;
		if (ch_in == 5'h0F)
			w = w | 8'hB0;
		if (w[6] && loop_own_r[5] && loop_own_r[4:0] != ch_in)
			w[6] = 1'b0;
		ctl_valid_out <= req_in;
		ctl_ch_out <= req_in ? ch_in : ~ctl_ch_out;
		ctl_byte_out <= req_in ? w : ~ctl_byte_out;
		if (req_in && w[6])
			loop_own_r <= {1'b1, ch_in};
		else if (req_in && loop_own_r == {1'b1, ch_in})
			loop_own_r <= 6'h00;
	end
endmodule

// *** bench/e1_framer_sync_and_channel_control_test.sv ***
module e1_framer_sync_and_channel_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 0, rst_n_in = 0, rx_valid_in = 0, tx_valid_in = 0, alt_digit_inversion_select = 0;
	logic maint = 0, crc_err = 0, req = 0, out_ready = 0, fa_d = 0;
	logic [7:0] rx_byte_in = 8'h00, tx_byte_in = 8'h00, req_byte = 8'h00;
	logic [4:0] tx_ts_in = 5'h00, req_ch = 5'h00;
	logic ctl_valid, rx_ready, out_valid, tx_bp, sig_valid, fa, mf, crc;
	logic [4:0] ctl_ch;
	logic [7:0] ctl_byte, sig_abcd;
	logic [2:0] tx_code;
	logic signed [3:0] tx_db;
	logic [3:0] sig_frame;
	efs_pkg::efs_rx_word_t out_word;
	int fails = 0, checks = 0, cyc = 0, fr = 0, errs = 0, fa_fell = 0;
	int seed = 32'h079440c4;
	bit drain = 0, synced = 0, sig_chk = 0, crc_on = 1, fas_bad = 0, mf_bad = 0, rdy = 0;
	localparam logic [5:0] CRC_PAT = 6'h0B;
	logic [7:0] ctl [32];
	logic [7:0] tx_last [32];
	logic [20:0] exp_q [$];
	logic [11:0] sig_q [$];

	efs_core #(.CRC_TO_CYC(200), .SEC_CYC(2000)) i_efs_core (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .ce_in(1'b1), .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in),
		.rx_ready_out(rx_ready), .tx_valid_in(tx_valid_in), .tx_ts_in(tx_ts_in),
		.tx_byte_in(tx_byte_in), .ctl_valid_in(ctl_valid), .ctl_ch_in(ctl_ch),
		.ctl_byte_in(ctl_byte), .alt_digit_inversion_select_in(alt_digit_inversion_select), .maint_in(maint),
		.crc_err_in(crc_err), .out_valid_out(out_valid), .out_ready_in(out_ready),
		.out_word_out(out_word), .tx_gain_code_out(tx_code), .tx_gain_db_out(tx_db),
		.tx_bypass_out(tx_bp), .sig_valid_out(sig_valid), .sig_frame_out(sig_frame),
		.sig_abcd_out(sig_abcd), .fa_sync_out(fa), .mf_sync_out(mf), .crc_sync_out(crc));

	efs_ctl_model i_efs_ctl_model (.clock_in(clock_in), .req_in(req), .ch_in(req_ch),
		.byte_in(req_byte), .ctl_valid_out(ctl_valid), .ctl_ch_out(ctl_ch),
		.ctl_byte_out(ctl_byte));

	// free-running bit-rate stand-in clock
	always #12.5 clock_in = ~clock_in;

	task check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic signed [3:0] gain_of(logic [2:0] code);
		return (code == 3'h7) ? 4'sh1 : 4'sh0 - $signed({1'b0, code});
	endfunction

	// gain code is meaningless on bypassed words, so it is not compared there
	function automatic logic [20:0] masked(efs_pkg::efs_rx_word_t w);
		if (w.bypass)
			w.gain_code = 3'h0;
		return w;
	endfunction

	function automatic logic [20:0] exp_word(logic [7:0] b, logic [4:0] ts);
		efs_pkg::efs_rx_word_t w;
		logic [7:0] c;
		c = ctl[ts - 5'h01];
		w.bypass = ts == 5'h00 || ts == 5'h10 || c[7];
		w.data = (c[6] && synced) ? tx_last[ts] : b;
		if (!w.bypass && alt_digit_inversion_select)
			w.data = w.data ^ 8'h55;
		w.ts = ts;
		w.gain_code = w.bypass ? 3'h0 : c[5:3];
		w.gain_db = w.bypass ? 4'sh0 : gain_of(c[5:3]);
		return w;
	endfunction

	// random payload must not imitate the alignment word or the search may lock on it
	function automatic logic [7:0] clean(logic [7:0] b);
		return (b[6:0] == 7'h1B) ? b ^ 8'h01 : b;
	endfunction

	task send_ctl(input logic [4:0] ch, input logic [7:0] b);
		// line source pauses while the controller talks
		rx_valid_in = 0;
		tx_valid_in = 0;
		crc_err = 0;
		req = 1;
		req_ch = ch;
		req_byte = b;
		@(negedge clock_in);
		req = 0;
		ctl[ch] = b;
		repeat (2) @(negedge clock_in);
	endtask

	task send_byte(input logic [7:0] b, input logic [4:0] ts);
		int n;
		logic [7:0] c;
		rx_valid_in = 1;
		rx_byte_in = b;
		tx_valid_in = 1;
		tx_ts_in = ts + 5'h10;
		tx_byte_in = $random(seed);
		crc_err = errs > 0;
		if (errs > 0)
			errs--;
		exp_q.push_back(exp_word(b, ts));
		// ready is looked at between edges, where it is settled
		n = 0;
		while (!rx_ready && n < 200) begin
			@(negedge clock_in);
			n++;
		end
		check(n < 200, 1);
		@(posedge clock_in);
		tx_last[tx_ts_in] = tx_byte_in;
		@(negedge clock_in);
		c = ctl[tx_ts_in - 5'h01];
		if (tx_ts_in[3:0] != 4'h0)
			check({c[7] ? 3'h0 : tx_code, tx_db, tx_bp}, c[7] ? 8'h01 : {c[2:0], gain_of(c[2:0]), 1'b0});
	endtask

	task run_frames(input int n);
		logic [7:0] b;
		repeat (n) begin
			for (int ts = 0; ts < 32; ts++) begin
				b = clean($random(seed));
				if (ts == 0) begin
					alt_digit_inversion_select = $random(seed);
					b = fr[0] ? {crc_on && CRC_PAT[5 - (fr / 2) % 6], 7'h5F} : 8'h9B;
					if (fas_bad && !fr[0])
						b = 8'h00;
				end else if (ts == 16 && fr % 16 == 0) begin
					b = mf_bad ? 8'hF0 : 8'h0B;
				end else if (ts == 16) begin
					b[7] = 1'b1;
					if (sig_chk)
						sig_q.push_back({fr[3:0], b});
				end
				send_byte(b, ts[4:0]);
				if (fr == 0 && ts == 7) begin
					check(rx_ready, 0); // eight words held, buffer refuses
					drain = 1;
				end
			end
			fr++;
		end
	endtask

	// choose the next stall at random, then compare the word the reader takes on that edge
	always @(negedge clock_in) begin
		// the word standing now is the one the coming edge pops
		rdy = drain && ($random(seed) % 4 != 0);
		if (out_valid && rdy && exp_q.size() > 0)
			check(masked(out_word), exp_q.pop_front());
		if (sig_valid && sig_q.size() > 0)
			check({sig_frame, sig_abcd}, sig_q.pop_front());
		out_ready <= rdy;
	end

	// cycle ceiling and count of frame-sync drops
	always @(posedge clock_in) begin
		cyc++;
		fa_d <= fa;
		if (fa_d && !fa)
			fa_fell++;
		if (cyc == 60000) begin
			fails++;
			end_sim();
		end
	end

	// main sequence
	initial begin
		for (int i = 0; i < 32; i++) begin
			ctl[i] = 8'h00;
			tx_last[i] = 8'h00;
		end
		ctl[15] = 8'hB0;
		repeat (8) @(negedge clock_in);
		rst_n_in = 1;
		check({rx_ready, out_valid, fa, mf, crc, tx_code, tx_bp}, 9'h100);
		send_ctl(5'h0F, 8'hBF);
		for (int i = 0; i < 31; i++)
			if (i != 15)
				send_ctl(i[4:0], {i[3], 1'b0, i[2:0], ~i[2:0]});
		run_frames(2);
		check({fa, mf, crc}, 3'h0);
		run_frames(1);
		check(fa, 1);
		synced = 1;
		run_frames(13);
		check(mf, 0);
		run_frames(1);
		check(mf, 1);
		sig_chk = 1;
		run_frames(26);
		check(crc, 1);
		send_ctl(5'h04, 8'h40);
		run_frames(2);
		send_ctl(5'h04, 8'h00);
		sig_chk = 0;
		send_ctl(5'h0F, 8'hFF);
		run_frames(2);
		send_ctl(5'h0F, 8'hBF);
		sig_chk = 1;
		run_frames(1);
		mf_bad = 1;
		run_frames(1);
		mf_bad = 0;
		run_frames(16);
		check(mf, 1);
		mf_bad = 1;
		run_frames(17);
		check(mf, 1);
		sig_chk = 0;
		run_frames(16);
		check({fa, mf}, 2'h2);
		mf_bad = 0;
		run_frames(15);
		check(mf, 1);
		fas_bad = 1;
		synced = 0;
		run_frames(6);
		check({fa, mf, crc}, 3'h0);
		fas_bad = 0;
		crc_on = 0;
		maint = 1;
		fa_fell = 0;
		run_frames(20);
		check(fa_fell != 0, 1);
		maint = 0;
		crc_on = 1;
		run_frames(30);
		check(crc, 1);
		maint = 1;
		fa_fell = 0;
		errs = 2000;
		run_frames(70);
		check(fa_fell != 0, 1);
		end_sim();
	end
endmodule
